// *** hdl/rim_pin_mux.sv ***
// source selection for one general purpose output pin
`timescale 1ns/1ps
module rim_pin_mux
    import rim_pkg::*;
(
    input wire logic [3:0] sel_in,
    rim_src_if.sink src,
    output logic pin_out
);
    always_comb begin
        unique case (sel_in)
            RIM_SEL_LOW: pin_out = 1'b0;
            RIM_SEL_HIGH: pin_out = 1'b1;
            RIM_SEL_RSVD: pin_out = 1'b0;
            RIM_SEL_TX_IRQ: pin_out = ~src.tx_irq;
            RIM_SEL_RX_IRQ: pin_out = ~src.rx_irq;
            RIM_SEL_PREEMPH: pin_out = ~src.preemph;
            RIM_SEL_NONAUDIO: pin_out = src.nonaudio;
            RIM_SEL_NONVALID: pin_out = src.nonvalid;
            RIM_SEL_CS_BIT: pin_out = src.cs_bit;
            RIM_SEL_USER_BIT: pin_out = src.user_bit;
            RIM_SEL_BLOCK: pin_out = src.block_start;
            RIM_SEL_COPY: pin_out = src.copy_bit;
            RIM_SEL_ORIGINAL: pin_out = src.original;
            RIM_SEL_PARITY: pin_out = src.parity_err;
            RIM_SEL_RX_SYNC: pin_out = src.rx_sync;
            RIM_SEL_TX_SYNC: pin_out = src.tx_sync;
        endcase
    end
endmodule

// *** hdl/rim_pkg.sv ***
// constants for the receiver trigger mode and output select register bank
package rim_pkg;
    // register indices and byte addresses (byte address is four times the index)
    localparam logic [7:0] RIM_IDX_TRIG_TWO = 8'h19;
    localparam logic [7:0] RIM_IDX_TRIG_THREE = 8'h1A;
    localparam logic [7:0] RIM_IDX_PIN_ONE = 8'h1B;
    localparam logic [7:0] RIM_IDX_PIN_TWO = 8'h1C;
    localparam logic [7:0] RIM_IDX_STATUS = 8'h20;
    localparam logic [11:0] RIM_ADDR_TRIG_TWO = {2'h0, RIM_IDX_TRIG_TWO, 2'h0};
    localparam logic [11:0] RIM_ADDR_TRIG_THREE = {2'h0, RIM_IDX_TRIG_THREE, 2'h0};
    localparam logic [11:0] RIM_ADDR_PIN_ONE = {2'h0, RIM_IDX_PIN_ONE, 2'h0};
    localparam logic [11:0] RIM_ADDR_PIN_TWO = {2'h0, RIM_IDX_PIN_TWO, 2'h0};
    localparam logic [11:0] RIM_ADDR_STATUS = {2'h0, RIM_IDX_STATUS, 2'h0};
    // field positions
    localparam int RIM_CRC_LSB = 6;
    localparam int RIM_PAR_LSB = 4;
    localparam int RIM_VAL_LSB = 2;
    localparam int RIM_BIP_LSB = 0;
    localparam int RIM_SLIP_LSB = 0;
    localparam int RIM_SEL_LSB = 0;
    // trigger source order on the flag and event vectors
    localparam int RIM_SRC_CRC = 0;
    localparam int RIM_SRC_PAR = 1;
    localparam int RIM_SRC_VAL = 2;
    localparam int RIM_SRC_BIP = 3;
    localparam int RIM_SRC_SLIP = 4;
    localparam int RIM_NUM_SRC = 5;
    // trigger mode codes
    localparam logic [1:0] RIM_TRIG_RISE = 2'h0;
    localparam logic [1:0] RIM_TRIG_FALL = 2'h1;
    localparam logic [1:0] RIM_TRIG_LEVEL = 2'h2;
    localparam logic [1:0] RIM_TRIG_RSVD = 2'h3;
    // reset values
    localparam logic [1:0] RIM_TRIG_RESET = 2'h0;
    localparam logic [3:0] RIM_SEL_RESET = 4'h0;
    // output source selector codes
    localparam logic [3:0] RIM_SEL_LOW = 4'h0;
    localparam logic [3:0] RIM_SEL_HIGH = 4'h1;
    localparam logic [3:0] RIM_SEL_RSVD = 4'h2;
    localparam logic [3:0] RIM_SEL_TX_IRQ = 4'h3;
    localparam logic [3:0] RIM_SEL_RX_IRQ = 4'h4;
    localparam logic [3:0] RIM_SEL_PREEMPH = 4'h5;
    localparam logic [3:0] RIM_SEL_NONAUDIO = 4'h6;
    localparam logic [3:0] RIM_SEL_NONVALID = 4'h7;
    localparam logic [3:0] RIM_SEL_CS_BIT = 4'h8;
    localparam logic [3:0] RIM_SEL_USER_BIT = 4'h9;
    localparam logic [3:0] RIM_SEL_BLOCK = 4'hA;
    localparam logic [3:0] RIM_SEL_COPY = 4'hB;
    localparam logic [3:0] RIM_SEL_ORIGINAL = 4'hC;
    localparam logic [3:0] RIM_SEL_PARITY = 4'hD;
    localparam logic [3:0] RIM_SEL_RX_SYNC = 4'hE;
    localparam logic [3:0] RIM_SEL_TX_SYNC = 4'hF;
    // bus answers
    localparam logic [1:0] RIM_RESP_OKAY = 2'h0;
    localparam logic [1:0] RIM_RESP_SLVERR = 2'h2;
endpackage

// *** hdl/rim_regs.sv ***
// trigger mode and output select register bank behind an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// - two-bit trigger modes: rise, fall, level, reserved
// - status CRC mode in bits 7:6
// - parity mode in bits 5:4
// - validity mode in bits 3:2
// - biphase mode in bits 1:0
// - slip mode bits 1:0, rest zero
// - pin one: low default, high, reserved
// - code 3: transmitter irq, active low
// - code 4: receiver irq, active low
// - code 5: pre-emphasis, active low
// - code 6: non-audio, active high
// - code 7: non-valid, active high
// - code 8: channel status bit stream
// - code 9: user data bit stream
// - code A: block start clock
// - code B: copy bit, low protected
// - code C: generation bit, high original
// - code D: parity error, active high
// - code E: receiver sync clock
// - code F: transmitter sync clock
// - pin two selector bits 3:0
module rim_regs
    import rim_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic MCLK_IN,
    input wire logic RESET_N_IN,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    input wire logic [4:0] RX_ERR_FLAGS_IN,
    output logic [4:0] RX_IRQ_EVENT_OUT,
    input wire logic TX_IRQ_IN,
    input wire logic RX_IRQ_IN,
    input wire logic RX_PREEMPH_IN,
    input wire logic RX_NONAUDIO_IN,
    input wire logic RX_NONVALID_IN,
    input wire logic RX_CS_BIT_IN,
    input wire logic RX_USER_BIT_IN,
    input wire logic RX_BLOCK_START_IN,
    input wire logic RX_COPY_IN,
    input wire logic RX_ORIGINAL_IN,
    input wire logic RX_PARITY_ERR_IN,
    input wire logic RX_SYNC_IN,
    input wire logic TX_SYNC_IN,
    output logic AUX_OUTPUT_ONE_OUT,
    output logic AUX_OUTPUT_TWO_OUT
);
    logic [1:0] status_crc_irq_trigger_r;
    logic [1:0] parity_irq_trigger_r;
    logic [1:0] validity_irq_trigger_r;
    logic [1:0] biphase_irq_trigger_r;
    logic [1:0] out_slip_irq_trigger_r;
    logic [3:0] pin_one_source_sel_r;
    logic [3:0] pin_two_source_sel_r;
    logic aw_have_r;
    logic w_have_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic w_strb0_r;
    logic wr_fire;
    logic wr_hit;
    logic [31:0] rd_data_nxt;
    logic [1:0] rd_resp_nxt;
    logic [4:0] cond;
    logic pin_one;
    logic pin_two;
    logic [7:0] trig_two_word;
    logic [7:0] trig_three_word;
    logic [ADDR_W-1:0] rd_addr_r;

    rim_src_if srcs ();

    assign srcs.tx_irq = TX_IRQ_IN;
    assign srcs.rx_irq = RX_IRQ_IN;
    assign srcs.preemph = RX_PREEMPH_IN;
    assign srcs.nonaudio = RX_NONAUDIO_IN;
    assign srcs.nonvalid = RX_NONVALID_IN;
    assign srcs.cs_bit = RX_CS_BIT_IN;
    assign srcs.user_bit = RX_USER_BIT_IN;
    assign srcs.block_start = RX_BLOCK_START_IN;
    assign srcs.copy_bit = RX_COPY_IN;
    assign srcs.original = RX_ORIGINAL_IN;
    assign srcs.parity_err = RX_PARITY_ERR_IN;
    assign srcs.rx_sync = RX_SYNC_IN;
    assign srcs.tx_sync = TX_SYNC_IN;

    assign trig_two_word = {status_crc_irq_trigger_r, parity_irq_trigger_r,
        validity_irq_trigger_r, biphase_irq_trigger_r};
    assign trig_three_word = {6'h00, out_slip_irq_trigger_r};

    assign wr_fire = aw_have_r & w_have_r & ~S_AXI_BVALID_OUT;
    assign wr_hit = (aw_addr_r == RIM_ADDR_TRIG_TWO) || (aw_addr_r == RIM_ADDR_TRIG_THREE)
        || (aw_addr_r == RIM_ADDR_PIN_ONE) || (aw_addr_r == RIM_ADDR_PIN_TWO);

    // write address and data taken in either order
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= '0;
            S_AXI_AWREADY_OUT <= 1'b1;
        end else if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= {S_AXI_AWADDR_IN[ADDR_W-1:2], 2'h0};
            S_AXI_AWREADY_OUT <= 1'b0;
        end else if (wr_fire) begin
            aw_have_r <= 1'b0;
        end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
            S_AXI_AWREADY_OUT <= 1'b1;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            w_have_r <= 1'b0;
            w_data_r <= '0;
            w_strb0_r <= 1'b0;
            S_AXI_WREADY_OUT <= 1'b1;
        end else if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            w_have_r <= 1'b1;
            w_data_r <= S_AXI_WDATA_IN;
            w_strb0_r <= S_AXI_WSTRB_IN[0];
            S_AXI_WREADY_OUT <= 1'b0;
        end else if (wr_fire) begin
            w_have_r <= 1'b0;
        end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
            S_AXI_WREADY_OUT <= 1'b1;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_BRESP_OUT <= RIM_RESP_OKAY;
        end else if (wr_fire) begin
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT <= wr_hit ? RIM_RESP_OKAY : RIM_RESP_SLVERR;
        end else if (S_AXI_BREADY_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
        end
    end

    // register updates, low byte lane only
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            status_crc_irq_trigger_r <= RIM_TRIG_RESET;
            parity_irq_trigger_r <= RIM_TRIG_RESET;
            validity_irq_trigger_r <= RIM_TRIG_RESET;
            biphase_irq_trigger_r <= RIM_TRIG_RESET;
            out_slip_irq_trigger_r <= RIM_TRIG_RESET;
            pin_one_source_sel_r <= RIM_SEL_RESET;
            pin_two_source_sel_r <= RIM_SEL_RESET;
        end else if (wr_fire && w_strb0_r) begin
            if (aw_addr_r == RIM_ADDR_TRIG_TWO) begin
                status_crc_irq_trigger_r <= w_data_r[RIM_CRC_LSB +: 2];
                parity_irq_trigger_r <= w_data_r[RIM_PAR_LSB +: 2];
                validity_irq_trigger_r <= w_data_r[RIM_VAL_LSB +: 2];
                biphase_irq_trigger_r <= w_data_r[RIM_BIP_LSB +: 2];
            end
            if (aw_addr_r == RIM_ADDR_TRIG_THREE) begin
                out_slip_irq_trigger_r <= w_data_r[RIM_SLIP_LSB +: 2];
            end
            if (aw_addr_r == RIM_ADDR_PIN_ONE) begin
                pin_one_source_sel_r <= w_data_r[RIM_SEL_LSB +: 4];
            end
            if (aw_addr_r == RIM_ADDR_PIN_TWO) begin
                pin_two_source_sel_r <= w_data_r[RIM_SEL_LSB +: 4];
            end
        end
    end

    // read decode
    always_comb begin
        rd_data_nxt = '0;
        rd_resp_nxt = RIM_RESP_OKAY;
        unique case ({S_AXI_ARADDR_IN[ADDR_W-1:2], 2'h0})
            RIM_ADDR_TRIG_TWO: rd_data_nxt[7:0] = trig_two_word;
            RIM_ADDR_TRIG_THREE: rd_data_nxt[7:0] = trig_three_word;
            RIM_ADDR_PIN_ONE: rd_data_nxt[3:0] = pin_one_source_sel_r;
            RIM_ADDR_PIN_TWO: rd_data_nxt[3:0] = pin_two_source_sel_r;
            RIM_ADDR_STATUS: rd_data_nxt[6:0] = {AUX_OUTPUT_TWO_OUT, AUX_OUTPUT_ONE_OUT,
                RX_IRQ_EVENT_OUT};
            default: rd_resp_nxt = RIM_RESP_SLVERR;
        endcase
    end

    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            S_AXI_ARREADY_OUT <= 1'b1;
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT <= '0;
            S_AXI_RRESP_OUT <= RIM_RESP_OKAY;
            rd_addr_r <= '0;
        end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            S_AXI_ARREADY_OUT <= 1'b0;
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RDATA_OUT <= rd_data_nxt;
            S_AXI_RRESP_OUT <= rd_resp_nxt;
            rd_addr_r <= {S_AXI_ARADDR_IN[ADDR_W-1:2], 2'h0};
        end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_ARREADY_OUT <= 1'b1;
        end
    end

    rim_trig_detect #(
        .N(RIM_NUM_SRC)
    ) u_trig (
        .clk_in(MCLK_IN),
        .rst_n_in(RESET_N_IN),
        .flag_in(RX_ERR_FLAGS_IN),
        .mode_in({out_slip_irq_trigger_r, biphase_irq_trigger_r, validity_irq_trigger_r,
            parity_irq_trigger_r, status_crc_irq_trigger_r}),
        .cond_out(cond)
    );

    rim_pin_mux u_pin_one (
        .sel_in(pin_one_source_sel_r),
        .src(srcs.sink),
        .pin_out(pin_one)
    );

    rim_pin_mux u_pin_two (
        .sel_in(pin_two_source_sel_r),
        .src(srcs.sink),
        .pin_out(pin_two)
    );

    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            RX_IRQ_EVENT_OUT <= '0;
        end else begin
            RX_IRQ_EVENT_OUT <= cond;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            AUX_OUTPUT_ONE_OUT <= 1'b0;
            AUX_OUTPUT_TWO_OUT <= 1'b0;
        end else begin
            AUX_OUTPUT_ONE_OUT <= pin_one;
            AUX_OUTPUT_TWO_OUT <= pin_two;
        end
    end

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);

    sequence s_trig_two_write;
        wr_fire && w_strb0_r && aw_addr_r == RIM_ADDR_TRIG_TWO;
    endsequence

    property p_reserved_silent;
        status_crc_irq_trigger_r == RIM_TRIG_RSVD |=> !RX_IRQ_EVENT_OUT[RIM_SRC_CRC];
    endproperty
    a_reserved_silent: assert property (p_reserved_silent) else $error("reserved mode fired");

    property p_crc_field;
        s_trig_two_write |=> status_crc_irq_trigger_r == $past(w_data_r[7:6]);
    endproperty
    a_crc_field: assert property (p_crc_field) else $error("crc mode not stored");

    property p_parity_field;
        s_trig_two_write |=> trig_two_word[5:4] == $past(w_data_r[5:4]);
    endproperty
    a_parity_field: assert property (p_parity_field) else $error("parity mode not stored");

    property p_low_fields;
        s_trig_two_write |=> trig_two_word[3:0] == $past(w_data_r[3:0]);
    endproperty
    a_low_fields: assert property (p_low_fields) else $error("low modes not stored");

    property p_three_zero;
        S_AXI_RVALID_OUT && rd_addr_r == RIM_ADDR_TRIG_THREE |-> S_AXI_RDATA_OUT[31:2] == '0;
    endproperty
    a_three_zero: assert property (p_three_zero) else $error("upper bits not zero");

    property p_rise_pulse;
        parity_irq_trigger_r == RIM_TRIG_RISE && $rose(RX_ERR_FLAGS_IN[RIM_SRC_PAR])
            ##1 parity_irq_trigger_r == RIM_TRIG_RISE |-> RX_IRQ_EVENT_OUT[RIM_SRC_PAR];
    endproperty
    a_rise_pulse: assert property (p_rise_pulse) else $error("rising edge missed");

    property p_level_follow;
        out_slip_irq_trigger_r == RIM_TRIG_LEVEL
            |=> RX_IRQ_EVENT_OUT[RIM_SRC_SLIP] == $past(RX_ERR_FLAGS_IN[RIM_SRC_SLIP]);
    endproperty
    a_level_follow: assert property (p_level_follow) else $error("level mode wrong");

    property p_forced_high;
        pin_one_source_sel_r == RIM_SEL_HIGH |=> AUX_OUTPUT_ONE_OUT;
    endproperty
    a_forced_high: assert property (p_forced_high) else $error("pin one not high");

    property p_rx_irq_low;
        pin_one_source_sel_r == RIM_SEL_RX_IRQ |=> AUX_OUTPUT_ONE_OUT == !$past(RX_IRQ_IN);
    endproperty
    a_rx_irq_low: assert property (p_rx_irq_low) else $error("rx irq polarity wrong");

    property p_preemph_low;
        pin_two_source_sel_r == RIM_SEL_PREEMPH
            |=> AUX_OUTPUT_TWO_OUT == !$past(RX_PREEMPH_IN);
    endproperty
    a_preemph_low: assert property (p_preemph_low) else $error("pre-emphasis wrong");

    property p_pin_two_write;
        wr_fire && w_strb0_r && aw_addr_r == RIM_ADDR_PIN_TWO
            |=> pin_two_source_sel_r == $past(w_data_r[3:0]);
    endproperty
    a_pin_two_write: assert property (p_pin_two_write) else $error("pin two not stored");
endmodule

// *** hdl/rim_src_if.sv ***
// receiver and transmitter status signals offered to the output pin selectors
`timescale 1ns/1ps
interface rim_src_if;
    logic tx_irq;
    logic rx_irq;
    logic preemph;
    logic nonaudio;
    logic nonvalid;
    logic cs_bit;
    logic user_bit;
    logic block_start;
    logic copy_bit;
    logic original;
    logic parity_err;
    logic rx_sync;
    logic tx_sync;
    modport src (output tx_irq, rx_irq, preemph, nonaudio, nonvalid, cs_bit, user_bit,
        block_start, copy_bit, original, parity_err, rx_sync, tx_sync);
    modport sink (input tx_irq, rx_irq, preemph, nonaudio, nonvalid, cs_bit, user_bit,
        block_start, copy_bit, original, parity_err, rx_sync, tx_sync);
endinterface

// *** hdl/rim_trig_detect.sv ***
// per-source edge or level trigger detection for receiver error flags
`timescale 1ns/1ps
module rim_trig_detect
    import rim_pkg::*;
#(
    parameter int N = 5
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [N-1:0] flag_in,
    input wire logic [2*N-1:0] mode_in,
    output logic [N-1:0] cond_out
);
    logic [N-1:0] prev_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_r <= '0;
        end else begin
            prev_r <= flag_in;
        end
    end

    for (genvar i = 0; i < N; i++) begin : g_src
        always_comb begin
            unique case (mode_in[2*i +: 2])
                RIM_TRIG_RISE: cond_out[i] = flag_in[i] & ~prev_r[i];
                RIM_TRIG_FALL: cond_out[i] = ~flag_in[i] & prev_r[i];
                RIM_TRIG_LEVEL: cond_out[i] = flag_in[i];
                RIM_TRIG_RSVD: cond_out[i] = 1'b0;
            endcase
        end
    end
endmodule

// *** sim/test_rx_irq_mode_and_gpo_select.sv ***
// self-checking bench for the trigger mode and output select register bank
`timescale 1ns/1ps
module test_rx_irq_mode_and_gpo_select import rim_pkg::*;;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [4:0] flags, ev, cur, prv;
    logic [12:0] st, st_cur;
    logic awready, wready, bvalid, arready, rvalid, pin1, pin2;
    logic [1:0] bresp, rresp, rs;
    logic [9:0] m;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    rim_regs dut_u (.MCLK_IN(clk), .RESET_N_IN(rst_n), .S_AXI_AWADDR_IN(awaddr),
        .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
        .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
        .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
        .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
        .S_AXI_RREADY_IN(rready), .RX_ERR_FLAGS_IN(flags), .RX_IRQ_EVENT_OUT(ev),
        .TX_IRQ_IN(st[0]), .RX_IRQ_IN(st[1]), .RX_PREEMPH_IN(st[2]), .RX_NONAUDIO_IN(st[3]),
        .RX_NONVALID_IN(st[4]), .RX_CS_BIT_IN(st[5]), .RX_USER_BIT_IN(st[6]),
        .RX_BLOCK_START_IN(st[7]), .RX_COPY_IN(st[8]), .RX_ORIGINAL_IN(st[9]),
        .RX_PARITY_ERR_IN(st[10]), .RX_SYNC_IN(st[11]), .TX_SYNC_IN(st[12]),
        .AUX_OUTPUT_ONE_OUT(pin1), .AUX_OUTPUT_TWO_OUT(pin2));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test;
        if (mismatches == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] resp);
        bit aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                aw_done = 1;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                w_done = 1;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic bus_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // write, then read back and compare word and answer codes
    task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
        bus_wr(a, d, 4'hF, rs);
        chk(rs, RIM_RESP_OKAY);
        bus_rd(a, rd, rs);
        chk(rs, RIM_RESP_OKAY);
        chk(rd, exp);
    endtask

    function automatic logic [4:0] ev_exp(input logic [9:0] md, input logic [4:0] c,
                                          input logic [4:0] p);
        logic [4:0] e;
        e = 5'h00;
        for (int k = 0; k < 5; k++) begin
            case (md[2*k +: 2])
                2'h0: e[k] = c[k] & ~p[k];
                2'h1: e[k] = ~c[k] & p[k];
                2'h2: e[k] = c[k];
                default: e[k] = 1'b0;
            endcase
        end
        return e;
    endfunction

    function automatic logic pin_exp(input logic [3:0] sel, input logic [12:0] s);
        logic [3:0] i;
        i = sel - 4'h3;
        case (sel)
            4'h0, 4'h2: return 1'b0;
            4'h1: return 1'b1;
            4'h3, 4'h4, 4'h5: return ~s[i];
            default: return s[i];
        endcase
    endfunction

    initial begin
        rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
        flags = 5'h00;
        st = 13'h0000;
        void'($urandom(32'h8c64));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            bus_rd(RIM_ADDR_TRIG_TWO + 12'(4 * i), rd, rs);
            chk(rd, 32'h0000_0000);
            chk(rs, RIM_RESP_OKAY);
        end
        bus_rd(12'h07C, rd, rs);
        chk(rd, 32'h0000_0000);
        chk(rs, RIM_RESP_SLVERR);
        bus_wr(12'h07C, 32'hFF, 4'hF, rs);
        chk(rs, RIM_RESP_SLVERR);
        wr_rd(RIM_ADDR_TRIG_THREE, 32'hFFFF_FFFE, 32'h0000_0002);
        wr_rd(RIM_ADDR_PIN_ONE, 32'hFFFF_FFFF, 32'h0000_000F);
        wr_rd(RIM_ADDR_PIN_TWO, 32'hFFFF_FFF5, 32'h0000_0005);
        bus_wr(RIM_ADDR_PIN_TWO, 32'h0A, 4'h0, rs);
        chk(rs, RIM_RESP_OKAY);
        bus_rd(RIM_ADDR_PIN_TWO, rd, rs);
        chk(rd, 32'h0000_0005);
        // modes forced per round, then random mixes
        for (int r = 0; r < 6; r++) begin
            for (int f = 0; f < 5; f++) begin
                m[2*f +: 2] = (r < 3) ? 2'(r) : 2'($urandom % 3);
            end
            wr_rd(RIM_ADDR_TRIG_TWO, {$urandom} & 32'hFFFF_FF00 | {m[1:0], m[3:2], m[5:4],
                  m[7:6]}, {24'h0, m[1:0], m[3:2], m[5:4], m[7:6]});
            wr_rd(RIM_ADDR_TRIG_THREE, {30'h0, m[9:8]}, {30'h0, m[9:8]});
            repeat (2) @(posedge clk);
            cur = flags;
            prv = flags;
            for (int k = 0; k < 40; k++) begin
                @(posedge clk);
                flags <= 5'($urandom);
                @(negedge clk);
                chk(ev, ev_exp(m, cur, prv));
                prv = cur;
                cur = flags;
            end
            @(posedge clk);
            flags <= 5'h00;
        end
        // every selector code on both pins
        for (int c = 0; c < 16; c++) begin
            wr_rd(RIM_ADDR_PIN_ONE, c, c);
            wr_rd(RIM_ADDR_PIN_TWO, 15 - c, 15 - c);
            repeat (2) @(posedge clk);
            st_cur = st;
            for (int k = 0; k < 12; k++) begin
                @(posedge clk);
                st <= 13'($urandom);
                @(negedge clk);
                chk(pin1, pin_exp(4'(c), st_cur));
                chk(pin2, pin_exp(4'(15 - c), st_cur));
                st_cur = st;
            end
        end
        // status word: pin one high, pin two low, no events
        wr_rd(RIM_ADDR_PIN_ONE, 32'h1, 32'h1);
        bus_rd(RIM_ADDR_STATUS, rd, rs);
        chk(rd, 32'h0000_0020);
        chk(rs, RIM_RESP_OKAY);
        bus_wr(RIM_ADDR_STATUS, 32'h0, 4'hF, rs);
        chk(rs, RIM_RESP_SLVERR);
        stop_test();
    end
endmodule
